// *** src/mpfc_consts.svh ***
`ifndef MPFC_CONSTS_SVH
`define MPFC_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define MPFC_OFF_ACCESS     12'h114
`define MPFC_OFF_DATA       12'h118
`define MPFC_OFF_FLOW       12'h11c
`define MPFC_OFF_MODE       12'h130

// ************************************************************
// field positions
// ************************************************************
`define MPFC_ACC_BUSY       0
`define MPFC_ACC_WRSEL      1
`define MPFC_ACC_IDX_LO     6
`define MPFC_ACC_IDX_HI     10
`define MPFC_ACC_PHY_LO     11
`define MPFC_ACC_PHY_HI     15
`define MPFC_FLOW_BUSY      0
`define MPFC_FLOW_EN        1
`define MPFC_FLOW_PASS      2
`define MPFC_FLOW_PT_LO     16
`define MPFC_FLOW_PT_HI     31
`define MPFC_MODE_FDX       0

// ************************************************************
// reset values
// ************************************************************
`define MPFC_RST_PHYADDR    5'h00
`define MPFC_RST_INDEX      5'h00
`define MPFC_RST_DATA       16'h0000
`define MPFC_RST_PTIME      16'h0000

// ************************************************************
// timing: one pause quantum is one slot time (512 bit times at 100 Mb/s)
// ************************************************************
`define MPFC_SLOT_TIME_NS   5120
`define MPFC_CLK_PERIOD_NS  20
`define MPFC_SLOT_CYCLES    (`MPFC_SLOT_TIME_NS / `MPFC_CLK_PERIOD_NS)

`endif

// *** src/mpfc_pkg.sv ***
package mpfc_pkg;

  // management cycle sequencer states, one-hot
  typedef enum logic [1:0] {
    MPFC_MG_IDLE = 2'b01,  // no access in flight
    MPFC_MG_WAIT = 2'b10   // request out, waiting on phy answer
  } mpfc_mg_state_t;

endpackage : mpfc_pkg

// *** src/mpfc_top.sv ***
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "mpfc_consts.svh"
// Operation
// - register index selects the phy register
// - write select chooses phy write or read
// - software sets busy; hardware clears when done
// - data held during write, valid after read
// - data register holds sixteen low bits
// - pause time field goes into frames
// - write with busy one sends control frame
// - pass bit sets filter bit on pause
// - every received frame forwarded with status
// - filtering modes override the pass bit
// - enable decodes pause, holds transmitter off
// - pause acted on only full duplex enabled
// - half duplex enable means back pressure
// - flow busy high while frame or pressure
module mpfc_top #(
  parameter int SLOT_CYC = `MPFC_SLOT_CYCLES  // cycles per pause quantum
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // internal phy management port
  output logic             phy_req,
  output logic             phy_write,
  output logic [4:0]       phy_addr,
  output logic [4:0]       phy_reg,
  output logic [15:0]      phy_wdata,
  input  wire logic        phy_ack,
  input  wire logic [15:0] phy_rdata,
  // control frame transmit side
  output logic             pause_tx_req,
  output logic [15:0]      pause_tx_time,
  output logic             backpressure,
  input  wire logic        ctrl_tx_done,
  output logic             tx_hold,
  // receive side
  input  wire logic        rx_frame_valid,
  input  wire logic        rx_is_pause,
  input  wire logic [15:0] rx_pause_time,
  input  wire logic        rx_addr_fail,
  input  wire logic        rx_filter_mode,
  output logic             rx_status_valid,
  output logic             rx_status_filter,
  output logic             rx_status_pause
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [4:0]  phy_addr_fld;   // software-owned phy address
  logic [4:0]  index_fld;      // phy register index
  logic        wr_sel;         // 1 = phy write
  logic        mgmt_busy;      // access in flight
  logic [15:0] mgmt_data;      // data register low half
  logic [15:0] pause_time;     // pause time field
  logic        pass_ctrl;      // pass control frames
  logic        fc_en;          // flow control enable
  logic        fc_busy;        // control transfer in flight
  logic        full_duplex;    // mac duplex mode
  mpfc_pkg::mpfc_mg_state_t mg_state;  // management sequencer
  logic [15:0] pause_left;     // quanta left to hold off
  logic [15:0] slot_cnt;       // cycles left in this quantum

  // ************************************************************
  // apb decode
  // ************************************************************
  logic wr_acc;   // write lands this edge
  logic hit_acc;  // address decodes
  logic w_access; // write strobes per register
  logic w_data;
  logic w_flow;
  logic w_mode;
  logic mg_start;
  logic fc_start;
  logic pause_act;

  assign wr_acc   = psel && penable && pready && pwrite;
  assign hit_acc  = (paddr == `MPFC_OFF_ACCESS) || (paddr == `MPFC_OFF_DATA) ||
                    (paddr == `MPFC_OFF_FLOW) || (paddr == `MPFC_OFF_MODE);
  assign w_access = wr_acc && (paddr == `MPFC_OFF_ACCESS);
  assign w_data   = wr_acc && (paddr == `MPFC_OFF_DATA);
  assign w_flow   = wr_acc && (paddr == `MPFC_OFF_FLOW);
  assign w_mode   = wr_acc && (paddr == `MPFC_OFF_MODE);
  // a new access only starts from idle; writes while busy are dropped
  assign mg_start = w_access && pwdata[`MPFC_ACC_BUSY] && !mgmt_busy;
  // busy written as zero starts nothing and leaves status alone
  assign fc_start = w_flow && pwdata[`MPFC_FLOW_BUSY] && !fc_busy;
  // pause is only acted on with flow control on in full duplex
  assign pause_act = rx_frame_valid && rx_is_pause && fc_en && full_duplex;

  // one wait-free access phase: pready rises the cycle after setup
  // no wait states, so a master never sees pready held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_acc;  // unmapped address answers an error
    end
  end

  // read data captured in setup so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `MPFC_OFF_ACCESS: prdata <= {16'h0000, phy_addr_fld, index_fld, 4'h0, wr_sel,
                                     mgmt_busy};
        `MPFC_OFF_DATA:   prdata <= {16'h0000, mgmt_data};
        `MPFC_OFF_FLOW:   prdata <= {pause_time, 13'h0000, pass_ctrl, fc_en, fc_busy};
        `MPFC_OFF_MODE:   prdata <= {31'h0000_0000, full_duplex};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // management access register fields
  // ************************************************************
  // fields only change when idle so an access in flight keeps its target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_addr_fld <= `MPFC_RST_PHYADDR;  // resets to zero; software must load it
      index_fld    <= `MPFC_RST_INDEX;
      wr_sel       <= 1'b0;
    end else if (w_access && !mgmt_busy) begin
      phy_addr_fld <= pwdata[`MPFC_ACC_PHY_HI:`MPFC_ACC_PHY_LO];
      index_fld    <= pwdata[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO];
      wr_sel       <= pwdata[`MPFC_ACC_WRSEL];
    end
  end

  // ************************************************************
  // management sequencer
  // ************************************************************
  // busy set by software, cleared by hardware on the phy answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mg_state  <= mpfc_pkg::MPFC_MG_IDLE;
      mgmt_busy <= 1'b0;
      phy_req   <= 1'b0;
    end else begin
      unique case (mg_state)
        mpfc_pkg::MPFC_MG_IDLE: begin
          if (mg_start) begin
            mg_state  <= mpfc_pkg::MPFC_MG_WAIT;
            mgmt_busy <= 1'b1;
            phy_req   <= 1'b1;
          end
        end
        mpfc_pkg::MPFC_MG_WAIT: begin
          if (phy_ack) begin
            mg_state  <= mpfc_pkg::MPFC_MG_IDLE;
            mgmt_busy <= 1'b0;
            phy_req   <= 1'b0;
          end
        end
        default: begin
          mg_state  <= mpfc_pkg::MPFC_MG_IDLE;
          mgmt_busy <= 1'b0;
          phy_req   <= 1'b0;
        end
      endcase
    end
  end

  // request fields are latched at start and held for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_write <= 1'b0;
      phy_addr  <= `MPFC_RST_PHYADDR;
      phy_reg   <= `MPFC_RST_INDEX;
      phy_wdata <= `MPFC_RST_DATA;
    end else if (mg_start) begin
      phy_write <= pwdata[`MPFC_ACC_WRSEL];
      phy_addr  <= pwdata[`MPFC_ACC_PHY_HI:`MPFC_ACC_PHY_LO];
      phy_reg   <= pwdata[`MPFC_ACC_IDX_HI:`MPFC_ACC_IDX_LO];
      phy_wdata <= mgmt_data;
    end
  end

  // data register: read result wins; software writes ignored while busy
  // a read answer and a software write cannot meet, since writes need idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_data <= `MPFC_RST_DATA;
    end else if (phy_req && phy_ack && !phy_write) begin
      mgmt_data <= phy_rdata;
    end else if (w_data && !mgmt_busy) begin
      mgmt_data <= pwdata[15:0];
    end
  end

  // ************************************************************
  // flow control register and control transfer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_time  <= `MPFC_RST_PTIME;
      pass_ctrl   <= 1'b0;
      fc_en       <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      if (w_flow) begin
        pause_time <= pwdata[`MPFC_FLOW_PT_HI:`MPFC_FLOW_PT_LO];
        pass_ctrl  <= pwdata[`MPFC_FLOW_PASS];
        fc_en      <= pwdata[`MPFC_FLOW_EN];
      end
      if (w_mode) begin
        full_duplex <= pwdata[`MPFC_MODE_FDX];
      end
    end
  end

  // full duplex sends a pause frame; half duplex with enable asserts pressure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_busy       <= 1'b0;
      pause_tx_req  <= 1'b0;
      backpressure  <= 1'b0;
      pause_tx_time <= `MPFC_RST_PTIME;
    end else if (fc_start) begin
      // half duplex with enable clear has nothing to send, so busy stays low
      // instead of waiting forever on a done pulse that never comes
      fc_busy       <= full_duplex || pwdata[`MPFC_FLOW_EN];
      pause_tx_req  <= full_duplex;
      backpressure  <= !full_duplex && pwdata[`MPFC_FLOW_EN];
      pause_tx_time <= pwdata[`MPFC_FLOW_PT_HI:`MPFC_FLOW_PT_LO];
    end else if (fc_busy && ctrl_tx_done) begin
      fc_busy      <= 1'b0;
      pause_tx_req <= 1'b0;
      backpressure <= 1'b0;
    end
  end

  // ************************************************************
  // receive pause decode and transmit hold-off
  // ************************************************************
  // a fresh pause reloads the count; zero time releases at once
  // the hold drops after the final cycle of the last quantum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_left <= 16'h0000;
      slot_cnt   <= 16'h0000;
      tx_hold    <= 1'b0;
    end else if (pause_act) begin
      pause_left <= rx_pause_time;
      slot_cnt   <= 16'(SLOT_CYC - 1);
      tx_hold    <= (rx_pause_time != 16'h0000);
    end else if (tx_hold) begin
      if (slot_cnt == 16'h0000) begin
        slot_cnt   <= 16'(SLOT_CYC - 1);
        pause_left <= pause_left - 16'h0001;
        tx_hold    <= (pause_left != 16'h0001);
      end else begin
        slot_cnt <= slot_cnt - 16'h0001;
      end
    end
  end

  // every frame gets a status word; filtering mode overrides pass bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status_valid  <= 1'b0;
      rx_status_filter <= 1'b0;
      rx_status_pause  <= 1'b0;
    end else begin
      rx_status_valid  <= rx_frame_valid;
      rx_status_pause  <= rx_frame_valid && rx_is_pause && fc_en;
      if (rx_filter_mode) begin
        rx_status_filter <= 1'b0;
      end else begin
        rx_status_filter <= rx_frame_valid && (rx_addr_fail ||
                            (pass_ctrl && rx_is_pause && fc_en));
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // all checks sample on the bus clock and sleep through reset
  default clocking mpfc_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mgmt_busy_clear: assert property (phy_req && phy_ack |=> !mgmt_busy && !phy_req)
    else $error("busy not cleared after phy answer");
  a_mgmt_req_busy: assert property (phy_req |-> mgmt_busy)
    else $error("phy request without busy");
  a_read_result: assert property (phy_req && phy_ack && !phy_write
                                  |=> mgmt_data == $past(phy_rdata))
    else $error("read result not loaded");
  a_write_data_held: assert property (phy_req && phy_write |=> $stable(phy_wdata))
    else $error("write data changed during access");
  a_phy_index: assert property (phy_req |-> phy_reg == index_fld)
    else $error("phy register index mismatch");
  a_pause_time_out: assert property (pause_tx_req |-> pause_tx_time == pause_time)
    else $error("pause time field mismatch");
  a_flow_start: assert property (fc_start && full_duplex |=> pause_tx_req && fc_busy)
    else $error("control frame not started");
  a_filter_prec: assert property (rx_frame_valid && rx_filter_mode
                                  |=> rx_status_valid && !rx_status_filter)
    else $error("filter mode did not override");
  a_pass_cleared: assert property (rx_frame_valid && rx_is_pause && !pass_ctrl &&
                                   !rx_addr_fail |=> !rx_status_filter)
    else $error("filter bit set with pass cleared");
  a_no_decode: assert property (rx_frame_valid && !(fc_en && full_duplex) && !tx_hold
                                |=> !tx_hold)
    else $error("pause acted on while disabled");
  // a zero-time pause may legally cut a hold short, so a fresh pause aborts the check
  a_hold_length: assert property (disable iff (!presetn || pause_act)
                                  $rose(tx_hold) |-> tx_hold [*8])
    else $error("hold released too early");
  a_idle_start: assert property (fc_start && !full_duplex && !pwdata[`MPFC_FLOW_EN]
                                 |=> !fc_busy)
    else $error("flow busy set with nothing to send");
  a_bp_half: assert property (backpressure |-> !full_duplex && fc_busy)
    else $error("back pressure outside half duplex");
  a_fc_busy: assert property (fc_busy && ctrl_tx_done && !fc_start
                              |=> !fc_busy && !pause_tx_req)
    else $error("flow busy not released");

  c_phy_read: cover property (phy_req && phy_ack && !phy_write);
  c_phy_write: cover property (phy_req && phy_ack && phy_write);
  c_pause_sent: cover property (pause_tx_req ##1 !pause_tx_req);
  c_hold: cover property ($rose(tx_hold));
  c_pressure: cover property (backpressure ##1 !backpressure);

endmodule : mpfc_top

// *** bench/mpfc_partner.sv ***
`timescale 1ns/1ps
// ************************************************************
// internal phy and link partner model
// ************************************************************
module mpfc_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        phy_req,
  input  wire logic        phy_write,
  input  wire logic [4:0]  phy_reg,
  input  wire logic [15:0] phy_wdata,
  output logic             phy_ack,
  output logic [15:0]      phy_rdata,
  input  wire logic        pause_tx_req,
  input  wire logic        backpressure,
  output logic             ctrl_tx_done
);
  logic [15:0] regs [32];   // phy register file
  int          mg_wait;     // cycles before the phy answers
  int          tx_wait;     // cycles left of a control transmission
  int          seed_p = 5;  // own stream, keeps the bench sequence fixed
  initial for (int i = 0; i < 32; i++) regs[i] = 16'(i * 257);
  // slow answers only: read data scrambles every cycle outside the ack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_ack   <= 1'b0;
      phy_rdata <= 16'h0000;
      mg_wait   <= 8;
    end else begin
      phy_ack   <= 1'b0;
      phy_rdata <= ~phy_rdata;
      if (phy_req && !phy_ack) begin
        if (mg_wait == 0) begin
          phy_ack <= 1'b1;
          mg_wait <= 8 + int'($unsigned($random(seed_p)) % 16);
          if (phy_write) regs[phy_reg] <= phy_wdata;
          else phy_rdata <= regs[phy_reg];
        end else begin
          mg_wait <= mg_wait - 1;
        end
      end
    end
  end
  // a pause frame or pressure burst ends with a one-cycle done pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_tx_done <= 1'b0;
      tx_wait      <= 8;
    end else begin
      ctrl_tx_done <= 1'b0;
      if ((pause_tx_req || backpressure) && !ctrl_tx_done) begin
        if (tx_wait == 0) begin
          ctrl_tx_done <= 1'b1;
          tx_wait      <= 8 + int'($unsigned($random(seed_p)) % 16);
        end else begin
          tx_wait <= tx_wait - 1;
        end
      end
    end
  end
endmodule : mpfc_partner

// *** bench/mac_phy_mgmt_and_pause_ctrl_bench.sv ***
`timescale 1ns/1ps
`include "mpfc_consts.svh"
module mac_phy_mgmt_and_pause_ctrl_bench;
  // ************************************************************
  // signals and model state
  // ************************************************************
  localparam int SLOT = 8;  // short quantum keeps hold counts small
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        phy_req, phy_write, phy_ack, pause_tx_req, backpressure;
  logic [4:0]  phy_addr, phy_reg;
  logic [15:0] phy_wdata, phy_rdata, pause_tx_time, rx_pause_time;
  logic        ctrl_tx_done, tx_hold, rx_frame_valid, rx_is_pause;
  logic        rx_addr_fail, rx_filter_mode;
  logic        rx_status_valid, rx_status_filter, rx_status_pause;
  int          n_mismatch, num_checks;
  int          seed = 80928;    // fixed seed for all stimulus
  logic [15:0] mdl_phy [32];    // expected phy register contents

  mpfc_top #(.SLOT_CYC(SLOT)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .phy_req, .phy_write,
    .phy_addr, .phy_reg, .phy_wdata, .phy_ack, .phy_rdata, .pause_tx_req,
    .pause_tx_time, .backpressure, .ctrl_tx_done, .tx_hold, .rx_frame_valid,
    .rx_is_pause, .rx_pause_time, .rx_addr_fail, .rx_filter_mode,
    .rx_status_valid, .rx_status_filter, .rx_status_pause);
  mpfc_partner u_phy (.pclk, .presetn, .phy_req, .phy_write, .phy_reg,
    .phy_wdata, .phy_ack, .phy_rdata, .pause_tx_req, .backpressure,
    .ctrl_tx_done);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard, far above the thousand or so cycles the run needs
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
  // every management cycle targets the internal phy address
  always @(posedge pclk) if (phy_ack === 1'b1) chk("phy_addr", 1, phy_addr);

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // one apb transfer, entered and left at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
    chk("pready", 1, pready);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rd_chk
  // software side: wait for a busy bit to drop before touching the register
  task automatic poll(input logic [11:0] a);
    logic [31:0] r;
    logic        e;
    int          i;
    r = 32'h1;
    for (i = 0; i < 100 && r[0] !== 1'b0; i++) apb(1'b0, a, 32'h0, r, e);
    chk("busy clear", 0, r[0]);
  endtask : poll
  // a phy access; reserved bits written as ones must read back as zero
  task automatic phy_op(input logic w, input logic [4:0] idx, input logic [15:0] d);
    if (w) wr(`MPFC_OFF_DATA, {16'hffff, d});
    wr(`MPFC_OFF_ACCESS, {16'hffff, 5'h01, idx, 4'hf, w, 1'b1});
    rd_chk("access busy", `MPFC_OFF_ACCESS, {16'h0, 5'h01, idx, 4'h0, w, 1'b1});
    wr(`MPFC_OFF_DATA, {16'h0, ~d});  // refused while busy
    poll(`MPFC_OFF_ACCESS);
    if (w) mdl_phy[idx] = d;
    chk("phy reg", {16'h0, mdl_phy[idx]}, {16'h0, u_phy.regs[idx]});
    rd_chk("data", `MPFC_OFF_DATA, {16'h0, w ? d : mdl_phy[idx]});
  endtask : phy_op
  // one received frame with random qualifiers, then the hold it causes
  task automatic rx_frame(input logic fdx, input logic en, input logic pass);
    logic        p, af, fm;
    logic [15:0] t;
    int          n;
    p  = 1'($random(seed));
    af = 1'($random(seed));
    fm = 1'($random(seed));
    t  = 16'($unsigned($random(seed)) % 4);
    rx_frame_valid <= 1'b1;
    rx_is_pause    <= p;
    rx_pause_time  <= t;
    rx_addr_fail   <= af;
    rx_filter_mode <= fm;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
    rx_is_pause    <= ~p;
    #1;
    chk("status valid", 1, rx_status_valid);
    chk("filter bit", fm ? 1'b0 : (af | (pass & p & en)), rx_status_filter);
    chk("pause flag", p & en, rx_status_pause);
    n = 0;
    while (tx_hold === 1'b1 && n < 200) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("hold cycles", (p & en & fdx) ? 32'(t * SLOT) : 32'h0, 32'(n));
    @(posedge pclk);
  endtask : rx_frame

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] r;
    logic        e, fdx, en, pass;
    logic [15:0] pt;
    {psel, penable, pwrite, paddr, pwdata, rx_frame_valid} = '0;
    {rx_is_pause, rx_pause_time, rx_addr_fail, rx_filter_mode} = '0;
    presetn = 1'b0;
    for (int i = 0; i < 32; i++) mdl_phy[i] = 16'(i * 257);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("access reset", `MPFC_OFF_ACCESS, 32'h0);
    rd_chk("data reset", `MPFC_OFF_DATA, 32'h0);
    rd_chk("flow reset", `MPFC_OFF_FLOW, 32'h0);
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    repeat (12) phy_op(1'($random(seed)), 5'($random(seed)), 16'($random(seed)));
    for (int cfg = 0; cfg < 8; cfg++) begin
      {pass, en, fdx} = 3'(cfg);
      pt = 16'($random(seed));
      wr(`MPFC_OFF_MODE, {31'h0, fdx});
      wr(`MPFC_OFF_FLOW, {pt, 13'h0, pass, en, 1'b0});
      rd_chk("flow fields", `MPFC_OFF_FLOW, {pt, 13'h0, pass, en, 1'b0});
      chk("no frame", 0, {pause_tx_req, backpressure});
      wr(`MPFC_OFF_FLOW, {pt, 13'h0, pass, en, 1'b1});
      #1;
      chk("pause req", fdx, pause_tx_req);
      chk("pressure", !fdx && en, backpressure);
      if (fdx) chk("pause time", pt, pause_tx_time);
      rd_chk("flow busy", `MPFC_OFF_FLOW, {pt, 13'h0, pass, en, fdx | en});
      poll(`MPFC_OFF_FLOW);
      chk("tx idle", 0, {pause_tx_req, backpressure});
      repeat (6) rx_frame(fdx, en, pass);
    end
    final_report();
  end
endmodule : mac_phy_mgmt_and_pause_ctrl_bench
